/* File: src/eepg_guard.sv */
`timescale 1ns/1ps
// Summary of operation
// - Lock clears accepted only first 64 cycles
// - Set lock bits stay until reset
// - Guard bits 7:5 read zero, ignored
// - Settings lock blocks settings-cell program/erase
// - Segment lock blocks its segment
// - Segments 32, 64, 128, 288 bytes
// - Single-chip: array at top page
// - Array mapped only if present bit set or in single-chip mode
// - Latch plus pump first write: both clear
// - Array writes ignored while pumping
// - No latched address means no operation
// - Latch clear: array reads like ROM
// - Locks never affect reads
// - Program ignores row/byte size bits
// - Row/bulk target any address within
// - Bulk on settings cell erases both
// - Control encodings select erase kinds
// - Register writes never alter settings cell
// - Pump writable only while latch set
// - Size bits: byte, row, bulk
// - New settings take effect after reset
module eepg_guard
	import eepg_pkg::*;
#(
	parameter int ADDR_W = 16                        // Bus address width
)
(
	input  wire logic              clk,              // 100 MHz clock
	input  wire logic              rst_n,            // Synchronous reset, active low
	input  wire logic              single_chip,      // Single-chip mode strap
	input  wire logic              bus_wr,           // Write strobe, one cycle
	input  wire logic              bus_rd,           // Read strobe, one cycle
	input  wire logic [ADDR_W-1:0] bus_addr,         // Bus address
	input  wire logic [7:0]        bus_wdata,        // Write data
	output logic      [7:0]        bus_rdata,        // Read data, one cycle after read
	output logic                   bus_hit,          // Read was decoded, with rdata
	output logic                   pump_active,      // Charge pump running an operation
	output logic                   pump_rc_clock     // Pump uses internal RC clock
);
	// ==========================================================
	// State
	logic [7:0]  cells [0:EEPG_ARRAY_BYTES-1];
	logic [7:0]  guard_reg, guard_next;
	logic [7:0]  ctl_reg, ctl_next;
	logic [7:0]  settings_cell_reg = EEPG_SETTINGS_INIT; // Nonvolatile cell, no reset, starts erased
	logic [7:0]  settings_live_reg;                  // Latched copy in use
	logic [6:0]  win_cnt_reg;
	logic        latched_reg;
	logic        lat_cell_reg;                       // Latched target is settings cell
	logic [8:0]  lat_addr_reg;
	logic [7:0]  lat_data_reg;
	logic        op_done_reg;
	logic        single_s1_reg, single_s2_reg, mode_live_reg;
	logic        rst_seen_reg;
	logic        clkpick_reg;
	logic [7:0]  rdata_reg;
	logic        hit_reg;
	logic        pump_reg;
	eepg_state_t state_reg, state_next;

	// ==========================================================
	// Decode
	wire         early_win   = (win_cnt_reg < 7'(EEPG_GUARD_WINDOW_CYCLES));
	wire [3:0]   page        = mode_live_reg ? EEPG_TOP_PAGE : settings_live_reg[7:4];
	wire         present     = mode_live_reg | settings_live_reg[EEPG_SET_PRESENT_BIT];
	wire         arr_sel     = present && (bus_addr[15:12] == page) && (bus_addr[11:9] == EEPG_ARRAY_HI[3:1]);
	wire         guard_sel   = (bus_addr == EEPG_WRITE_GUARD_ADDR);
	wire         ctl_sel     = (bus_addr == EEPG_PROGRAM_CTL_ADDR);
	wire         set_sel     = (bus_addr == EEPG_SETTINGS_ADDR);
	wire         opt_sel     = (bus_addr == EEPG_OPTION_ADDR);
	wire [8:0]   off         = bus_addr[8:0];
	wire         latch_on    = ctl_reg[EEPG_CTL_LATCH_BIT];
	wire         pump_on     = ctl_reg[EEPG_CTL_PUMP_BIT];
	wire         erase_on    = ctl_reg[EEPG_CTL_ERASE_BIT];
	wire         size_byte   = ctl_reg[EEPG_CTL_BYTE_BIT];
	wire         size_row    = ctl_reg[EEPG_CTL_ROW_BIT];

	// Segment index of the latched offset
	wire [1:0]   seg = (lat_addr_reg <= EEPG_SEG0_END) ? 2'h0 :
	                   (lat_addr_reg <= EEPG_SEG1_END) ? 2'h1 :
	                   (lat_addr_reg <= EEPG_SEG2_END) ? 2'h2 : 2'h3;
	wire         cell_ok  = !guard_reg[EEPG_GUARD_CELL_BIT];
	wire         bulk     = erase_on && !size_byte && !size_row;
	// Bulk erase touches every segment, so any segment lock blocks it
	wire         arr_ok   = bulk ? (guard_reg[3:0] == 4'h0) : !guard_reg[seg];
	wire         op_ok    = lat_cell_reg ? (cell_ok && (!bulk || arr_ok)) : arr_ok;

	// Guard: sets always stick, clears only early; single-chip and expanded are both normal modes
	always_comb
	begin
		guard_next = guard_reg;
		if (bus_wr && guard_sel)
		begin
			if (early_win)
				guard_next = bus_wdata & EEPG_GUARD_MASK;
			else
				guard_next = guard_reg | (bus_wdata & EEPG_GUARD_MASK);
		end
	end

	// Control register next value
	always_comb
	begin
		ctl_next = ctl_reg;
		if (bus_wr && ctl_sel)
		begin
			ctl_next = bus_wdata & EEPG_CTL_MASK;
			if (!latch_on)
			begin
				ctl_next[EEPG_CTL_PUMP_BIT] = 1'b0;
				if (bus_wdata[EEPG_CTL_LATCH_BIT] && bus_wdata[EEPG_CTL_PUMP_BIT])
					ctl_next[EEPG_CTL_LATCH_BIT] = 1'b0;
			end
		end
	end

	// Sequence state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			EEPG_IDLE:    if (ctl_next[EEPG_CTL_LATCH_BIT]) state_next = EEPG_ARMED;
			EEPG_ARMED:
			begin
				if (!ctl_next[EEPG_CTL_LATCH_BIT]) state_next = EEPG_IDLE;
				else if (ctl_next[EEPG_CTL_PUMP_BIT]) state_next = EEPG_PUMPING;
				else if (bus_wr && (arr_sel || set_sel)) state_next = EEPG_LATCHED;
			end
			EEPG_LATCHED:
			begin
				if (!ctl_next[EEPG_CTL_LATCH_BIT]) state_next = EEPG_IDLE;
				else if (ctl_next[EEPG_CTL_PUMP_BIT]) state_next = EEPG_PUMPING;
			end
			EEPG_PUMPING:
			begin
				if (!ctl_next[EEPG_CTL_PUMP_BIT])
					state_next = ctl_next[EEPG_CTL_LATCH_BIT] ? EEPG_ARMED : EEPG_IDLE;
			end
			default:      state_next = EEPG_IDLE;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			guard_reg     <= EEPG_GUARD_RESET;
			ctl_reg       <= EEPG_CTL_RESET;
			win_cnt_reg   <= 7'h00;
			state_reg     <= EEPG_IDLE;
			latched_reg   <= 1'b0;
			lat_cell_reg  <= 1'b0;
			lat_addr_reg  <= 9'h000;
			lat_data_reg  <= 8'h00;
			op_done_reg   <= 1'b0;
			rst_seen_reg  <= 1'b1;
			clkpick_reg   <= 1'b0;
			rdata_reg     <= 8'h00;
			hit_reg       <= 1'b0;
			pump_reg      <= 1'b0;
		end
		else
		begin
			guard_reg    <= guard_next;
			ctl_reg      <= ctl_next;
			state_reg    <= state_next;
			rst_seen_reg <= 1'b0;
			pump_reg     <= (state_next == EEPG_PUMPING) && latched_reg && op_ok;
			if (early_win)
				win_cnt_reg <= win_cnt_reg + 7'h01;
			if (bus_wr && opt_sel)
				clkpick_reg <= bus_wdata[EEPG_OPT_CLKPICK_BIT];
			// Latch address/data only while armed; pumping drops writes
			if (state_reg == EEPG_ARMED && state_next == EEPG_LATCHED)
			begin
				latched_reg  <= 1'b1;
				lat_cell_reg <= set_sel;
				lat_addr_reg <= off;
				lat_data_reg <= bus_wdata;
			end
			else if (state_next == EEPG_IDLE || state_next == EEPG_ARMED)
				latched_reg <= 1'b0;
			op_done_reg <= (state_next == EEPG_PUMPING) && (state_reg == EEPG_PUMPING);
			// Array and register reads, no lock involvement
			hit_reg   <= bus_rd && (arr_sel || guard_sel || ctl_sel || set_sel || opt_sel);
			rdata_reg <= 8'h00;
			if (bus_rd)
			begin
				if (guard_sel)
					rdata_reg <= guard_reg & EEPG_GUARD_MASK;
				else if (ctl_sel)
					rdata_reg <= ctl_reg;
				else if (set_sel)
					rdata_reg <= settings_live_reg;
				else if (opt_sel)
					rdata_reg <= {1'b0, clkpick_reg, 6'h00};
				else if (arr_sel)
					rdata_reg <= cells[off];
			end
		end
	end

	// Mode strap caught through two flops, held from release
	always_ff @(posedge clk)
	begin
		single_s1_reg <= single_chip;
		single_s2_reg <= single_s1_reg;
		if (rst_seen_reg)
			mode_live_reg <= single_s2_reg;
	end

	// Settings copy reloaded only at reset release
	always_ff @(posedge clk)
	begin
		if (rst_seen_reg)
			settings_live_reg <= settings_cell_reg;
	end

	// ==========================================================
	// Cell array: act once, on the first pumping edge with a valid latch
	wire fire = pump_reg && !op_done_reg;
	always_ff @(posedge clk)
	begin
		// Only the program/erase path writes the settings cell
		if (fire && lat_cell_reg)
			settings_cell_reg <= erase_on ? EEPG_ERASED_BYTE : (settings_cell_reg & lat_data_reg);
	end

	genvar gi;
	generate
		for (gi = 0; gi < EEPG_ARRAY_BYTES; gi++)
		begin : g_cell
			localparam logic [8:0] IDX = 9'(gi);
			wire hit_byte = (lat_addr_reg == IDX);
			wire hit_row  = (lat_addr_reg[8:4] == IDX[8:4]);
			wire erase_me = lat_cell_reg ? bulk :
			                (size_byte ? hit_byte : (size_row ? hit_row : 1'b1));
			always_ff @(posedge clk)
			begin
				if (fire && op_ok)
				begin
					if (erase_on && erase_me)
						cells[gi] <= EEPG_ERASED_BYTE;
					else if (!erase_on && !lat_cell_reg && hit_byte)
						cells[gi] <= cells[gi] & lat_data_reg;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Outputs
	assign bus_rdata     = rdata_reg;
	assign bus_hit       = hit_reg;
	assign pump_active   = pump_reg;
	assign pump_rc_clock = clkpick_reg;
endmodule : eepg_guard

/* File: src/eepg_pkg.sv */
package eepg_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [15:0] EEPG_WRITE_GUARD_ADDR  = 16'h1035;
	localparam logic [15:0] EEPG_PROGRAM_CTL_ADDR  = 16'h103B;
	localparam logic [15:0] EEPG_SETTINGS_ADDR     = 16'h103F;
	localparam logic [15:0] EEPG_OPTION_ADDR       = 16'h1039;
	// ==========================================================
	// Field positions
	localparam int EEPG_GUARD_CELL_BIT   = 4;
	localparam int EEPG_CTL_PUMP_BIT     = 0;
	localparam int EEPG_CTL_LATCH_BIT    = 1;
	localparam int EEPG_CTL_ERASE_BIT    = 2;
	localparam int EEPG_CTL_ROW_BIT      = 3;
	localparam int EEPG_CTL_BYTE_BIT     = 4;
	localparam int EEPG_OPT_CLKPICK_BIT  = 6;
	localparam int EEPG_SET_PRESENT_BIT  = 0;
	// ==========================================================
	// Masks, reset values and page decode
	localparam logic [7:0] EEPG_GUARD_MASK   = 8'h1F;
	localparam logic [7:0] EEPG_GUARD_RESET  = 8'h1F;
	localparam logic [7:0] EEPG_CTL_MASK     = 8'h1F;
	localparam logic [7:0] EEPG_CTL_RESET    = 8'h00;
	localparam logic [7:0] EEPG_ERASED_BYTE  = 8'hFF;
	localparam logic [7:0] EEPG_SETTINGS_INIT = 8'hFF;
	localparam logic [3:0] EEPG_TOP_PAGE     = 4'hF;
	localparam logic [3:0] EEPG_ARRAY_HI     = 4'hE;
	// ==========================================================
	// Segment bounds (array offsets, last byte of segments 0..2)
	localparam logic [8:0] EEPG_SEG0_END = 9'h01F;
	localparam logic [8:0] EEPG_SEG1_END = 9'h05F;
	localparam logic [8:0] EEPG_SEG2_END = 9'h0DF;
	// ==========================================================
	// Timing, array size and sequence states
	localparam int EEPG_GUARD_WINDOW_CYCLES = 64;
	localparam int EEPG_ARRAY_BYTES         = 512;
	typedef enum logic [1:0] {EEPG_IDLE, EEPG_ARMED, EEPG_LATCHED, EEPG_PUMPING} eepg_state_t;
endpackage : eepg_pkg

/* File: test/eepg_guard_props.sv */
`timescale 1ns/1ps
// ==========================================================
// Port-level checks for the program/erase guard
module eepg_guard_props
	import eepg_pkg::*;
#(
	parameter int ADDR_W = 16                      // Bus address width
)
(
	input wire logic              clk,             // Clock
	input wire logic              rst_n,           // Sync reset
	input wire logic              single_chip,     // Mode strap
	input wire logic              bus_wr,          // Write strobe
	input wire logic              bus_rd,          // Read strobe
	input wire logic [ADDR_W-1:0] bus_addr,        // Address
	input wire logic [7:0]        bus_wdata,       // Write data
	input wire logic [7:0]        bus_rdata,       // Read data
	input wire logic              bus_hit,         // Read decoded
	input wire logic              pump_active,     // Pump running
	input wire logic              pump_rc_clock    // RC clock pick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Control writes are the only legal cause of pump changes
	wire ctl_wr = bus_wr && (bus_addr == EEPG_PROGRAM_CTL_ADDR);
	property p_rdata_idle; !bus_hit |-> bus_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data set without hit");
	property p_hit_cause; bus_hit |-> $past(bus_rd); endproperty
	a_hit_cause: assert property (p_hit_cause) else $error("hit without read");
	property p_guard_hi; bus_rd && bus_addr == EEPG_WRITE_GUARD_ADDR |=> bus_hit && bus_rdata[7:5] == 3'h0; endproperty
	a_guard_hi: assert property (p_guard_hi) else $error("guard upper bits not zero");
	property p_pump_rise; $rose(pump_active) |-> $past(ctl_wr) && $past(bus_wdata[1:0]) == 2'h3; endproperty
	a_pump_rise: assert property (p_pump_rise) else $error("pump started without control write");
	property p_pump_off; pump_active && ctl_wr && !bus_wdata[0] |=> !pump_active; endproperty
	a_pump_off: assert property (p_pump_off) else $error("pump did not stop");
	property p_pump_hold; pump_active && !ctl_wr |=> pump_active; endproperty
	a_pump_hold: assert property (p_pump_hold) else $error("pump dropped on its own");
	property p_rc; bus_wr && bus_addr == EEPG_OPTION_ADDR |=> pump_rc_clock == $past(bus_wdata[6]); endproperty
	a_rc: assert property (p_rc) else $error("clock pick not copied");
	property p_ctl_read; bus_rd && bus_addr == EEPG_PROGRAM_CTL_ADDR |=> bus_hit; endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control read not decoded");
endmodule : eepg_guard_props
bind eepg_guard eepg_guard_props #(.ADDR_W(ADDR_W)) props_inst (.clk(clk), .rst_n(rst_n), .single_chip(single_chip),
	.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.bus_hit(bus_hit), .pump_active(pump_active), .pump_rc_clock(pump_rc_clock));

/* File: test/eepg_guard_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the program/erase guard
module eepg_guard_test
	import eepg_pkg::*;
;
	logic        clk, rst_n, single_chip, bus_wr, bus_rd, bus_hit, pump_active, pump_rc_clock, pa;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata, bus_rdata, v;
	int          fails = 0;
	int          comparisons = 0;
	eepg_guard eepg_guard_inst (.clk(clk), .rst_n(rst_n), .single_chip(single_chip), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.bus_hit(bus_hit), .pump_active(pump_active), .pump_rc_clock(pump_rc_clock));
	eepg_host eepg_host_inst (.clk(clk), .bus_rdata(bus_rdata), .pump_active(pump_active), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Scenarios
	task automatic t_guard;
		eepg_host_inst.wr(EEPG_WRITE_GUARD_ADDR, 8'hE1);
		eepg_host_inst.rd(EEPG_WRITE_GUARD_ADDR, v);
		chk(v, 8'h01);
		repeat (64) @(posedge clk);
		eepg_host_inst.wr(EEPG_WRITE_GUARD_ADDR, 8'h00);
		eepg_host_inst.rd(EEPG_WRITE_GUARD_ADDR, v);
		chk(v, 8'h01);
	endtask : t_guard
	task automatic t_regs;
		eepg_host_inst.wr(EEPG_SETTINGS_ADDR, 8'h00);
		eepg_host_inst.rd(EEPG_SETTINGS_ADDR, v);
		chk(v, 8'hFF);
		eepg_host_inst.wr(EEPG_OPTION_ADDR, 8'h40);
		#1 chk({7'h0, pump_rc_clock}, 8'h01);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h03);
		eepg_host_inst.rd(EEPG_PROGRAM_CTL_ADDR, v);
		chk(v, 8'h00);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h02);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h03);
		#1 chk({7'h0, pump_active}, 8'h00);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h00);
	endtask : t_regs
	task automatic t_prog;
		eepg_host_inst.op(8'h16, 16'hFE20, 8'h00, pa);
		chk({7'h0, pa}, 8'h01);
		eepg_host_inst.op(8'h02, 16'hFE20, 8'h5A, pa);
		eepg_host_inst.rd(16'hFE20, v);
		chk(v, 8'h5A);
		eepg_host_inst.op(8'h16, 16'hFE21, 8'h00, pa);
		eepg_host_inst.rd(16'hFE20, v);
		chk(v, 8'h5A);
		// Program with the byte size bit set, then a stray store mid-pump
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h12);
		eepg_host_inst.wr(16'hFE21, 8'h3C);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h13);
		eepg_host_inst.wr(16'hFE21, 8'h00);
		eepg_host_inst.wr(EEPG_PROGRAM_CTL_ADDR, 8'h00);
		eepg_host_inst.rd(16'hFE21, v);
		chk(v, 8'h3C);
	endtask : t_prog
	task automatic t_lock_row;
		eepg_host_inst.op(8'h16, 16'hFE1F, 8'h00, pa);
		chk({7'h0, pa}, 8'h00);
		eepg_host_inst.op(8'h0E, 16'hFE2F, 8'h00, pa);
		chk({7'h0, pa}, 8'h01);
		eepg_host_inst.rd(16'hFE20, v);
		chk(v, 8'hFF);
		eepg_host_inst.rd(16'hFE21, v);
		chk(v, 8'hFF);
	endtask : t_lock_row
	// Mid-run reset; strap held long enough for its two flops
	task automatic pulse_reset(input logic sc);
		@(posedge clk);
		rst_n       <= 1'b0;
		single_chip <= sc;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : pulse_reset
	// Settings cell unmaps the array, then single-chip maps it back at the top page
	task automatic t_settings;
		eepg_host_inst.op(8'h16, EEPG_SETTINGS_ADDR, 8'h00, pa);
		chk({7'h0, pa}, 8'h01);
		eepg_host_inst.op(8'h02, EEPG_SETTINGS_ADDR, 8'h7E, pa);
		eepg_host_inst.rd(EEPG_SETTINGS_ADDR, v);
		chk(v, 8'hFF);
		pulse_reset(1'b0);
		eepg_host_inst.rd(EEPG_SETTINGS_ADDR, v);
		chk(v, 8'h7E);
		eepg_host_inst.rd(16'h7E20, v);
		chk({7'h0, bus_hit}, 8'h00);
		chk(v, 8'h00);
		eepg_host_inst.op(8'h16, EEPG_SETTINGS_ADDR, 8'h00, pa);
		chk({7'h0, pa}, 8'h00);
		pulse_reset(1'b1);
		eepg_host_inst.wr(EEPG_WRITE_GUARD_ADDR, 8'h00);
		eepg_host_inst.rd(EEPG_WRITE_GUARD_ADDR, v);
		chk(v, 8'h00);
		eepg_host_inst.rd(16'hFE20, v);
		chk({7'h0, bus_hit}, 8'h01);
		chk(v, 8'hFF);
		eepg_host_inst.op(8'h02, 16'hFE20, 8'h12, pa);
		chk({7'h0, pa}, 8'h01);
		eepg_host_inst.op(8'h06, EEPG_SETTINGS_ADDR, 8'h00, pa);
		chk({7'h0, pa}, 8'h01);
		eepg_host_inst.rd(16'hFE20, v);
		chk(v, 8'hFF);
		eepg_host_inst.rd(EEPG_SETTINGS_ADDR, v);
		chk(v, 8'h7E);
	endtask : t_settings
	// ==========================================================
	// Clock, main sequence and watchdog
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		rst_n = 1'b0;
		single_chip = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_guard;
		t_regs;
		t_prog;
		t_lock_row;
		t_settings;
		wrap_up;
	end
	// Whole run needs well under 500 cycles
	initial
	begin
		#20000;
		fails++;
		wrap_up;
	end
endmodule : eepg_guard_test

/* File: test/eepg_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host CPU model: byte writes and reads, program/erase steps
module eepg_host
	import eepg_pkg::*;
#(
	parameter int PUMP_WAIT = 4                  // Stands in for the 10 ms pump time
)
(
	input  wire logic        clk,                // Clock
	input  wire logic [7:0]  bus_rdata,          // Read data
	input  wire logic        pump_active,        // Pump running
	output logic             bus_wr,             // Write strobe
	output logic             bus_rd,             // Read strobe
	output logic      [15:0] bus_addr,           // Address
	output logic      [7:0]  bus_wdata           // Write data
);
	// Idle bus at time zero
	initial
	begin
		{bus_wr, bus_rd, bus_addr, bus_wdata} = 26'h0;
	end
	// Released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
		@(posedge clk);
		{bus_wr, bus_addr, bus_wdata} <= {1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		{bus_rd, bus_addr} <= {1'b1, a};
		@(posedge clk);
		{bus_rd, bus_addr} <= {1'b0, ~a};
		#1 d = bus_rdata;
	endtask : rd
	// Arm, latch target, pump, wait, pump off, clear
	task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, output logic pa);
		wr(EEPG_PROGRAM_CTL_ADDR, c);
		wr(a, d);
		wr(EEPG_PROGRAM_CTL_ADDR, c | 8'h01);
		#1 pa = pump_active;
		repeat (PUMP_WAIT) @(posedge clk);
		wr(EEPG_PROGRAM_CTL_ADDR, c);
		wr(EEPG_PROGRAM_CTL_ADDR, 8'h00);
	endtask : op
endmodule : eepg_host
